/* pkg/gis_consts.vh */
// Register map, field positions, reset values and timing counts for the
// gated integrator sequencer. Assumes a 250 MHz mclk and 32-bit Avalon-MM data.
`ifndef GIS_CONSTS_VH
`define GIS_CONSTS_VH

`define GIS_CLK_MHZ       250
`define GIS_CYC_PER_SEC   250000000

// Byte offsets
`define GIS_A_CTRL        8'h00
`define GIS_A_PERIOD      8'h04
`define GIS_A_RESET       8'h08
`define GIS_A_SETTLE      8'h0C
`define GIS_A_SETUP       8'h10
`define GIS_A_ISOW        8'h14
`define GIS_A_ISOOFF      8'h18
`define GIS_A_AVG         8'h1C
`define GIS_A_GAIN        8'h20
`define GIS_A_RECIP       8'h24
`define GIS_A_TMO         8'h28
`define GIS_A_STATUS      8'h2C
`define GIS_A_RESULT      8'h30

// Control bits
`define GIS_C_INIT        0
`define GIS_C_STOP        1
`define GIS_C_WARM        2
`define GIS_C_EXT         3
`define GIS_C_FALL        4
`define GIS_C_BIGCAP      5
`define GIS_C_CAL         6
`define GIS_C_HV          7
`define GIS_C_SAFE        8
`define GIS_C_CURR        9
`define GIS_CTRL_W        10
`define GIS_CTRL_KEEP     10'h3F8

// Reset values (cycles of mclk, except gain and reciprocal)
`define GIS_RV_PERIOD     32'h017D7840
`define GIS_RV_SETTLE     32'h000000FA
`define GIS_RV_SETUP      32'h00000FA0
`define GIS_RV_ISOW       32'h0000007D
`define GIS_RV_ISOOFF     32'h0000003F
`define GIS_RV_GAIN       16'h0100
`define GIS_RV_RECIP      16'h0001
`define GIS_DEF_RST_SMALL 32'h000009C4
`define GIS_DEF_RST_LARGE 32'h000061A8

// Overrange at 98 % of the signed 16-bit span
`define GIS_OVR_POS       16'sh7D70
`define GIS_OVR_NEG       16'sh8290
`define GIS_Q_SHIFT       8
`define GIS_I_SHIFT       16

`endif

/* verification/gated_integrator_sequencer_tb_top.sv */
// Self-checking bench: Avalon register tasks, queued expected readings, ADC model.
// Assumes a 100-cycle one-second tick so the host timeout fits the run.
`timescale 1ns/10ps
`include "gis_consts.vh"
module gated_integrator_sequencer_tb_top;
   logic               mclk = 0, rstn = 0, avs_read = 0, avs_write = 0, host_activity = 0, gate_in = 0;
   logic [7:0]         avs_address = 8'h00;
   logic [31:0]        avs_writedata = 32'h00000000, rd, lfsr = 32'hFD0BF5FB, old_p;
   logic [3:0]         be = 4'hF;
   logic signed [15:0] lo_v = -16'sd200, hi_v = 16'sd1000;
   wire                avs_waitrequest, adc_convert, adc_valid, irs, iso, cap_select, cal_source_on, hv_enable;
   wire                freq_monitor, reading_valid, reading_overrange;
   wire [15:0]         adc_data, dac_data;
   wire [31:0]         avs_readdata, reading_data;
   logic [32:0]        expq[$];
   int                 fails = 0, n_tests = 0, n_read = 0, n_rst = 0, n_fm = 0;
   logic               irs_q = 1'b1, fm_q = 1'b0;
   logic [7:0]         rv_a [7] = '{`GIS_A_PERIOD, `GIS_A_SETTLE, `GIS_A_SETUP, `GIS_A_ISOW, `GIS_A_ISOOFF, `GIS_A_GAIN, 8'h40};
   logic [31:0]        rv_d [7] = '{`GIS_RV_PERIOD, `GIS_RV_SETTLE, `GIS_RV_SETUP, `GIS_RV_ISOW, `GIS_RV_ISOOFF,
                                    32'h00000100, 32'h00000000};
   logic [7:0]         cf_a [8] = '{`GIS_A_PERIOD, `GIS_A_RESET, `GIS_A_SETTLE, `GIS_A_SETUP, `GIS_A_ISOW, `GIS_A_ISOOFF,
                                    `GIS_A_AVG, `GIS_A_RECIP};
   logic [31:0]        cf_d [8] = '{32'h000000C8, 32'h00000014, 32'h0000000A, 32'h00000028, 32'h00000005,
                                    32'h00000008, 32'h00000011, 32'h00008000};

   always #2 mclk = ~mclk;

   gis_sequencer #(.CYC_PER_SEC(100)) uut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(be), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .host_activity(host_activity), .gate_in(gate_in), .adc_convert(adc_convert),
      .adc_valid(adc_valid), .adc_data(adc_data), .integrator_reset_switch(irs), .input_isolation_switch(iso),
      .cap_select(cap_select), .cal_source_on(cal_source_on), .hv_enable(hv_enable), .dac_data(dac_data),
      .freq_monitor(freq_monitor), .reading_valid(reading_valid), .reading_data(reading_data),
      .reading_overrange(reading_overrange));
   gis_adc_model u_adc (.mclk(mclk), .rstn(rstn), .adc_convert(adc_convert), .integrator_reset_switch(irs),
      .lo_v(lo_v), .hi_v(hi_v), .adc_valid(adc_valid), .adc_data(adc_data));

   function automatic [31:0] lfsr_next(input [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Byte lane mask as the bus defines it
   function automatic [31:0] lanes(input [3:0] b);
      lanes = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction

   task automatic cmp(input [32:0] got, input [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until the edge that samples waitrequest low
   task automatic bus(input bit wr, input [7:0] a, input [31:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wait_rd(input int k);
      int tgt;
      tgt = n_read + k;
      while (n_read < tgt) @(posedge mclk);
   endtask

   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Any reading without a queued expectation is a spurious result
   always @(posedge mclk) begin
      irs_q <= irs;
      if (irs === 1'b1 && irs_q === 1'b0) n_rst++;
      fm_q  <= freq_monitor;
      if (freq_monitor === 1'b1 && fm_q === 1'b0) n_fm++;
      if (reading_valid === 1'b1) begin
         n_read++;
         if (expq.size() == 0) begin
            fails++;
            $display("[ERR] %0t unexpected reading", $time);
         end else
            cmp({reading_overrange, reading_data}, expq.pop_front());
      end
   end

   initial begin
      #(4 * 40000);
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test;
   end

   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      foreach (rv_a[i]) begin
         bus(0, rv_a[i], 32'h0);
         cmp(rd, rv_d[i]);
      end
      repeat (3) begin
         lfsr = lfsr_next(lfsr);
         bus(1, `GIS_A_PERIOD, lfsr);
         bus(0, `GIS_A_PERIOD, 32'h0);
         cmp(rd, lfsr);
      end
      // Partial lane write must keep the lanes left disabled
      old_p = rd;
      lfsr = lfsr_next(lfsr);
      be <= lfsr[3:0];
      bus(1, `GIS_A_PERIOD, ~lfsr);
      be <= 4'hF;
      bus(0, `GIS_A_PERIOD, 32'h0);
      cmp(rd, (old_p & ~lanes(lfsr[3:0])) | (~lfsr & lanes(lfsr[3:0])));
      bus(1, `GIS_A_RESULT, 32'h12345678);
      bus(0, `GIS_A_RESULT, 32'h0);
      cmp(rd, 32'h0);
      foreach (cf_a[i]) bus(1, cf_a[i], cf_d[i]);
      host_activity <= 1'b1;
      @(posedge mclk);
      host_activity <= 1'b0;
      n_rst = 0;
      bus(1, `GIS_A_CTRL, 32'h000001E1);
      repeat (2) @(posedge mclk);
      cmp({cap_select, cal_source_on, hv_enable}, 3'b111);
      expq.push_back(33'd4800);
      wait_rd(1);
      cmp(n_rst, 2);
      cmp(dac_data, 16'h92C0);
      hi_v = 16'sd2000;
      expq.push_back(33'd6800);
      wait_rd(1);
      expq.push_back(33'd8800);
      wait_rd(1);
      hi_v = 16'sd32200;
      expq.push_back({1'b1, 32'd69200});
      wait_rd(1);
      bus(1, `GIS_A_CTRL, 32'h000001E6);
      hi_v = 16'sd1000;
      bus(1, `GIS_A_CTRL, 32'h000003E1);
      repeat (150) @(posedge mclk);
      // abort mid-ramp, no reading may follow
      bus(1, `GIS_A_CTRL, 32'h000003E4);
      repeat (600) @(posedge mclk);
      lo_v <= -16'sd600;
      bus(1, `GIS_A_CTRL, 32'h000003E1);
      expq.push_back(33'd3200);
      wait_rd(1);
      bus(1, `GIS_A_CTRL, 32'h000001E6);
      bus(1, `GIS_A_CTRL, 32'h000001E9);
      repeat (100) @(posedge mclk);
      cmp(irs, 1'b1);
      gate_in <= 1'b1;
      expq.push_back(33'd6400);
      wait_rd(1);
      gate_in <= 1'b0;
      bus(1, `GIS_A_CTRL, 32'h000001E6);
      bus(1, `GIS_A_TMO, 32'h00000002);
      repeat (90) @(posedge mclk);
      cmp(hv_enable, 1'b1);
      repeat (230) @(posedge mclk);
      cmp({hv_enable, cal_source_on}, 2'b00);
      cmp(n_fm != 0, 1'b1);
      end_of_test;
   end
endmodule // gated_integrator_sequencer_tb_top

/* verification/gis_adc_model.sv */
// ADC partner: answers each convert request, alternating prompt and slow.
// Assumes samples early in the ramp read lo_v and late ones read hi_v.
`timescale 1ns/10ps
module gis_adc_model (
   input  wire               mclk,
   input  wire               rstn,
   input  wire               adc_convert,
   input  wire               integrator_reset_switch,
   input  wire signed [15:0] lo_v,
   input  wire signed [15:0] hi_v,
   output logic              adc_valid,
   output logic [15:0]       adc_data
);
   int   ramp;
   int   busy;
   logic slow;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ramp      <= 0;
         busy      <= 0;
         slow      <= 1'b0;
         adc_valid <= 1'b0;
         adc_data  <= 16'h0000;
      end else begin
         ramp      <= integrator_reset_switch ? 0 : ramp + 1;
         adc_valid <= 1'b0;
         // Data only means something in the valid cycle; toggled elsewhere
         adc_data  <= ~adc_data;
         if (busy > 0) begin
            busy <= busy - 1;
            if (busy == 1) begin
               adc_valid <= 1'b1;
               adc_data  <= (ramp < 100) ? lo_v : hi_v;
            end
         end else if (adc_convert) begin
            busy <= slow ? 6 : 2;
            slow <= ~slow;
         end
      end
   end
endmodule // gis_adc_model

/* verification/gis_seq_monitor.sv */
// Port checker for the integrator sequencer.
// Assumes the bench programs settle 10, isolation width 5, offset 8.
`timescale 1ns/10ps
module gis_seq_monitor (
   input wire mclk,
   input wire rstn,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire adc_convert,
   input wire integrator_reset_switch,
   input wire input_isolation_switch,
   input wire reading_valid,
   input wire reading_overrange
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   chk_bus_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait cycle on new request");
   chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   chk_conv_pulse: assert property (adc_convert |=> !adc_convert)
      else $error("convert longer than one cycle");
   chk_conv_in_ramp: assert property (integrator_reset_switch |-> !adc_convert)
      else $error("conversion during reset");
   chk_settle_quiet: assert property ($fell(integrator_reset_switch) |-> (!adc_convert)[*8])
      else $error("conversion inside settle time");
   chk_reset_hold: assert property ($rose(integrator_reset_switch) |-> integrator_reset_switch[*8])
      else $error("reset interval too short");
   chk_iso_width: assert property ($fell(input_isolation_switch) |->
      (!input_isolation_switch)[*5] ##1 input_isolation_switch)
      else $error("isolation opening width wrong");
   chk_iso_before_rst: assert property ($fell(input_isolation_switch) |->
      !integrator_reset_switch ##[6:10] $rose(integrator_reset_switch))
      else $error("isolation opening not tied to reset closing");
   chk_valid_lag: assert property (reading_valid |->
      $past(integrator_reset_switch, 2) && !$past(integrator_reset_switch, 3))
      else $error("reading not two cycles after reset closing");
   chk_valid_pulse: assert property (reading_valid |=> !reading_valid)
      else $error("reading strobe longer than one cycle");
   cov_reading: cover property (reading_valid);
   cov_overrange: cover property (reading_valid && reading_overrange);
   cov_iso_open: cover property ($fell(input_isolation_switch));
endmodule // gis_seq_monitor
bind gis_sequencer gis_seq_monitor u_mon (.mclk(mclk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .adc_convert(adc_convert), .integrator_reset_switch(integrator_reset_switch),
   .input_isolation_switch(input_isolation_switch), .reading_valid(reading_valid),
   .reading_overrange(reading_overrange));

/* verilog/gis_sequencer.v */
// Gated integrator sequencer: switch timing, ADC sampling, averaging,
// monitor outputs and host timeout supervision, with an Avalon-MM slave.
// Assumes ADC and microcontroller signals share mclk; gate is asynchronous.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "gis_consts.vh"

module gis_sequencer #(
   parameter CYC_PER_SEC = `GIS_CYC_PER_SEC
) (
   input  wire        mclk,
   input  wire        rstn,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [3:0]  avs_byteenable,
   input  wire [31:0] avs_writedata,
   output wire        avs_waitrequest,
   output reg  [31:0] avs_readdata,
   input  wire        host_activity,
   input  wire        gate_in,
   output reg         adc_convert,
   input  wire        adc_valid,
   input  wire [15:0] adc_data,
   output reg         integrator_reset_switch,
   output reg         input_isolation_switch,
   output reg         cap_select,
   output reg         cal_source_on,
   output reg         hv_enable,
   output reg  [15:0] dac_data,
   output reg         freq_monitor,
   output reg         reading_valid,
   output reg  [31:0] reading_data,
   output reg         reading_overrange
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ARM  = 3'h1;
   localparam [2:0] ST_RST  = 3'h2;
   localparam [2:0] ST_SETL = 3'h3;
   localparam [2:0] ST_SAMS = 3'h4;
   localparam [2:0] ST_INT  = 3'h5;
   localparam [2:0] ST_SETU = 3'h6;

   reg         rs1_r;
   reg         rs2_r;
   wire        rst_n = rs2_r;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end

   // Registers
   reg  [`GIS_CTRL_W-1:0] ctrl_r;
   reg  [31:0] per_r;
   reg  [31:0] rstt_r;
   reg  [31:0] setl_r;
   reg  [31:0] setu_r;
   reg  [31:0] isow_r;
   reg  [31:0] isoo_r;
   reg  [7:0]  avg_r;
   reg  [15:0] gain_r;
   reg  [15:0] recip_r;
   reg  [15:0] tmo_r;
   reg         ack_r;
   reg         init_p;
   reg         stop_p;
   reg         warm_p;
   reg  [2:0]  st_r;
   reg         safe_r;
   reg  [31:0] rcnt_r;

   wire        req = avs_read | avs_write;
   wire        wr_go = avs_write & ack_r;
   wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   assign avs_waitrequest = req & ~ack_r;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] m;
      begin
         merge = (old & ~m) | (wd & m);
      end
   endfunction

   wire [31:0] ctrl_w = merge({22'h0, ctrl_r}, avs_writedata, bmask);
   wire [31:0] gain_w = merge({16'h0, gain_r}, avs_writedata, bmask);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r  <= {`GIS_CTRL_W{1'b0}};
         per_r   <= `GIS_RV_PERIOD;
         rstt_r  <= 32'h0;
         setl_r  <= `GIS_RV_SETTLE;
         setu_r  <= `GIS_RV_SETUP;
         isow_r  <= `GIS_RV_ISOW;
         isoo_r  <= `GIS_RV_ISOOFF;
         avg_r   <= 8'h0;
         gain_r  <= `GIS_RV_GAIN;
         recip_r <= `GIS_RV_RECIP;
         tmo_r   <= 16'h0;
         ack_r   <= 1'b0;
         init_p  <= 1'b0;
         stop_p  <= 1'b0;
         warm_p  <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         ack_r  <= req & ~ack_r;
         init_p <= 1'b0;
         stop_p <= 1'b0;
         warm_p <= 1'b0;
         if (req & ~ack_r) begin
            case (avs_address)
               `GIS_A_CTRL:   avs_readdata <= {22'h0, ctrl_r & `GIS_CTRL_KEEP};
               `GIS_A_PERIOD: avs_readdata <= per_r;
               `GIS_A_RESET:  avs_readdata <= rstt_r;
               `GIS_A_SETTLE: avs_readdata <= setl_r;
               `GIS_A_SETUP:  avs_readdata <= setu_r;
               `GIS_A_ISOW:   avs_readdata <= isow_r;
               `GIS_A_ISOOFF: avs_readdata <= isoo_r;
               `GIS_A_AVG:    avs_readdata <= {24'h0, avg_r};
               `GIS_A_GAIN:   avs_readdata <= {16'h0, gain_r};
               `GIS_A_RECIP:  avs_readdata <= {16'h0, recip_r};
               `GIS_A_TMO:    avs_readdata <= {16'h0, tmo_r};
               `GIS_A_STATUS: avs_readdata <= {16'h0, rcnt_r[11:0], safe_r, st_r};
               `GIS_A_RESULT: avs_readdata <= reading_data;
               default:       avs_readdata <= 32'h0;
            endcase
         end
         if (wr_go) begin
            case (avs_address)
               `GIS_A_CTRL: begin
                  ctrl_r <= ctrl_w[`GIS_CTRL_W-1:0] & `GIS_CTRL_KEEP;
                  init_p <= ctrl_w[`GIS_C_INIT];
                  stop_p <= ctrl_w[`GIS_C_STOP];
                  warm_p <= ctrl_w[`GIS_C_WARM];
               end
               `GIS_A_PERIOD: per_r   <= merge(per_r, avs_writedata, bmask);
               `GIS_A_RESET:  rstt_r  <= merge(rstt_r, avs_writedata, bmask);
               `GIS_A_SETTLE: setl_r  <= merge(setl_r, avs_writedata, bmask);
               `GIS_A_SETUP:  setu_r  <= merge(setu_r, avs_writedata, bmask);
               `GIS_A_ISOW:   isow_r  <= merge(isow_r, avs_writedata, bmask);
               `GIS_A_ISOOFF: isoo_r  <= merge(isoo_r, avs_writedata, bmask);
               `GIS_A_AVG:    avg_r   <= avs_byteenable[0] ? avs_writedata[7:0] : avg_r;
               `GIS_A_GAIN:   gain_r  <= gain_w[15:0];
               `GIS_A_RECIP:  recip_r <= avs_byteenable[1:0] == 2'h3 ? avs_writedata[15:0] : recip_r;
               `GIS_A_TMO:    tmo_r   <= avs_byteenable[1:0] == 2'h3 ? avs_writedata[15:0] : tmo_r;
               default: ;
            endcase
         end
      end
   end

   // Gate input: three flops, change accepted once the last two agree
   reg  [2:0]  gs_r;
   reg         gst_r;
   reg         gprev_r;
   wire        trig = ctrl_r[`GIS_C_FALL] ? (gprev_r & ~gst_r) : (~gprev_r & gst_r);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gs_r    <= 3'h0;
         gst_r   <= 1'b0;
         gprev_r <= 1'b0;
      end else begin
         gs_r    <= {gs_r[1:0], gate_in};
         if (gs_r[1] == gs_r[2])
            gst_r <= gs_r[2];
         gprev_r <= gst_r;
      end
   end

   // Host timeout supervision
   reg  [27:0] sdiv_r;
   reg  [15:0] secs_r;
   wire        act = host_activity | wr_go | (avs_read & ack_r);
   wire        sec_tick = (sdiv_r == CYC_PER_SEC - 1);
   wire        tmo_hit = (tmo_r != 16'h0) && (secs_r >= tmo_r);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sdiv_r <= 28'h0;
         secs_r <= 16'h0;
         safe_r <= 1'b0;
      end else begin
         if (act || sec_tick)
            sdiv_r <= 28'h0;
         else
            sdiv_r <= sdiv_r + 28'h1;
         if (act)
            secs_r <= 16'h0;
         else if (sec_tick && secs_r != 16'hFFFF)
            secs_r <= secs_r + 16'h1;
         if (tmo_hit)
            safe_r <= 1'b1;
         else if (act)
            safe_r <= 1'b0;
      end
   end

   // Sequencer
   reg  [31:0] tmr_r;
   reg  [31:0] pcnt_r;
   reg  [31:0] isoc_r;
   reg  [4:0]  ns_r;
   reg         wait_r;
   reg  signed [19:0] sst_r;
   reg  signed [19:0] sen_r;
   reg  signed [20:0] hist_r [0:15];
   reg  [3:0]  ptr_r;
   reg  [4:0]  fill_r;
   reg  signed [24:0] rsum_r;
   reg         upd_r;
   reg         ovr_r;
   reg  signed [42:0] q_r;
   reg         qv_r;
   reg         qovr_r;
   integer     i;

   wire [4:0]  nread = {1'b0, avg_r[3:0]} + 5'h1;
   wire [3:0]  nint_m1 = avg_r[7:4];
   wire [31:0] rst_len = (rstt_r != 32'h0) ? rstt_r :
                         ctrl_r[`GIS_C_BIGCAP] ? `GIS_DEF_RST_LARGE : `GIS_DEF_RST_SMALL;
   wire signed [15:0] sd = adc_data;
   wire        ovr_now = adc_valid && (sd > `GIS_OVR_POS || sd < `GIS_OVR_NEG);
   wire signed [20:0] diff = {sen_r[19], sen_r} - {sst_r[19], sst_r};
   wire        abort = warm_p | stop_p | safe_r;
   wire        sam_done = (ns_r == nread) && !wait_r;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r   <= ST_IDLE;
         tmr_r  <= 32'h0;
         pcnt_r <= 32'h0;
         isoc_r <= 32'h0;
         ns_r   <= 5'h0;
         wait_r <= 1'b0;
         sst_r  <= 20'sh0;
         sen_r  <= 20'sh0;
         ptr_r  <= 4'h0;
         fill_r <= 5'h0;
         rsum_r <= 25'sh0;
         upd_r  <= 1'b0;
         ovr_r  <= 1'b0;
         adc_convert <= 1'b0;
         integrator_reset_switch <= 1'b1;
         input_isolation_switch  <= 1'b1;
         for (i = 0; i < 16; i = i + 1)
            hist_r[i] <= 21'sh0;
      end else begin
         adc_convert <= 1'b0;
         upd_r <= 1'b0;
         if (tmr_r != 32'h0)
            tmr_r <= tmr_r - 32'h1;
         pcnt_r <= pcnt_r + 32'h1;
         if (isoc_r != 32'h0)
            isoc_r <= isoc_r - 32'h1;
         input_isolation_switch <= (isoc_r == 32'h0);
         if (wait_r && adc_valid) begin
            wait_r <= 1'b0;
            if (st_r == ST_SAMS)
               sst_r <= sst_r + sd;
            else
               sen_r <= sen_r + sd;
         end else if (!wait_r && ns_r != nread && (st_r == ST_SAMS || st_r == ST_SETU)) begin
            adc_convert <= 1'b1;
            wait_r <= 1'b1;
            ns_r <= ns_r + 5'h1;
         end
         // Overrange persists until the reading leaves; a new hit wins
         if (ovr_now)
            ovr_r <= 1'b1;
         else if (upd_r)
            ovr_r <= 1'b0;
         if (abort) begin
            // drop partial data; no conversion may start with the switch closed
            st_r   <= ST_IDLE;
            adc_convert <= 1'b0;
            fill_r <= 5'h0;
            rsum_r <= 25'sh0;
            ptr_r  <= 4'h0;
            wait_r <= 1'b0;
            isoc_r <= 32'h0;
            integrator_reset_switch <= 1'b1;
            for (i = 0; i < 16; i = i + 1)
               hist_r[i] <= 21'sh0;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  if (init_p)
                     st_r <= ST_ARM;
               end
               ST_ARM: begin
                  if (!ctrl_r[`GIS_C_EXT] || trig) begin
                     st_r  <= ST_RST;
                     tmr_r <= rst_len;
                     integrator_reset_switch <= 1'b1;
                  end
               end
               ST_RST: begin
                  if (tmr_r == 32'h0) begin
                     integrator_reset_switch <= 1'b0;
                     st_r   <= ST_SETL;
                     tmr_r  <= setl_r;
                     pcnt_r <= 32'h0;
                  end
               end
               ST_SETL: begin
                  if (tmr_r == 32'h0) begin
                     st_r  <= ST_SAMS;
                     ns_r  <= 5'h0;
                     sst_r <= 20'sh0;
                  end
               end
               ST_SAMS: begin
                  if (sam_done)
                     st_r <= ST_INT;
               end
               ST_INT: begin
                  if (pcnt_r >= per_r) begin
                     st_r  <= ST_SETU;
                     tmr_r <= setu_r;
                     ns_r  <= 5'h0;
                     sen_r <= 20'sh0;
                  end
               end
               ST_SETU: begin
                  if (tmr_r == isoo_r && isoc_r == 32'h0)
                     isoc_r <= isow_r;
                  if (tmr_r == 32'h0 && sam_done) begin
                     integrator_reset_switch <= 1'b1;
                     st_r  <= ST_RST;
                     tmr_r <= rst_len;
                     hist_r[ptr_r] <= diff;
                     rsum_r <= rsum_r + diff - hist_r[ptr_r];
                     ptr_r  <= (ptr_r == nint_m1) ? 4'h0 : ptr_r + 4'h1;
                     if (fill_r <= {1'b0, nint_m1})
                        fill_r <= fill_r + 5'h1;
                     upd_r  <= (fill_r >= {1'b0, nint_m1});
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end

   wire signed [42:0] q_nxt = rsum_r * $signed({1'b0, gain_r});
   // current via loaded reciprocal of interval
   wire signed [59:0] i_full = q_r * $signed({1'b0, recip_r});
   wire signed [42:0] q_sh = q_r >>> `GIS_Q_SHIFT;
   wire signed [59:0] i_sh = i_full >>> (`GIS_Q_SHIFT + `GIS_I_SHIFT);
   wire [31:0] out_nxt = ctrl_r[`GIS_C_CURR] ? i_sh[31:0] : q_sh[31:0];
   reg  [23:0] facc_r;
   wire [15:0] mag = out_nxt[31] ? (16'h0 - out_nxt[15:0]) : out_nxt[15:0];

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q_r    <= 43'sh0;
         qv_r   <= 1'b0;
         qovr_r <= 1'b0;
         rcnt_r <= 32'h0;
         facc_r <= 24'h0;
         reading_valid     <= 1'b0;
         reading_data      <= 32'h0;
         reading_overrange <= 1'b0;
         dac_data     <= 16'h8000;
         freq_monitor <= 1'b0;
         cap_select    <= 1'b0;
         cal_source_on <= 1'b0;
         hv_enable     <= 1'b0;
      end else begin
         qv_r   <= upd_r & ~abort;
         qovr_r <= ovr_r | ovr_now;
         if (upd_r)
            q_r <= q_nxt;
         reading_valid <= qv_r & ~abort;
         if (qv_r & ~abort) begin
            reading_data      <= out_nxt;
            reading_overrange <= qovr_r;
            rcnt_r <= rcnt_r + 32'h1;
            dac_data <= {~out_nxt[15], out_nxt[14:0]};
         end
         facc_r <= facc_r + {8'h0, mag};
         freq_monitor <= facc_r[23];
         cap_select <= ctrl_r[`GIS_C_BIGCAP];
         cal_source_on <= ctrl_r[`GIS_C_CAL] & ~safe_r;
         hv_enable <= ctrl_r[`GIS_C_HV] & ~(safe_r & ctrl_r[`GIS_C_SAFE]);
      end
   end

endmodule // gis_sequencer
